// *** core/bctc_core.sv ***
// Purpose: Mode control, counter, lamp, alert and scan for the charge timer
// Assumes: Oscillator ticks and pin inputs are asynchronous; srst is power-on
// Notes:   Tick is one oscillator period; in scan mode the test clock edge ticks
`timescale 1ns/1ps

module bctc_core
   import bctc_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic             osc_tick_in,
   input  wire logic             drain_detect_n,
   input  wire logic             charger_present,
   input  wire logic             scheme_pick,
   input  wire logic             scan_select,
   input  wire logic             test_clock_in,
   input  wire logic             scan_serial_in,
   output logic                  switch_on,
   output logic                  switch_off_n,
   output logic                  switch_off_oe,
   output logic                  status_lamp_n,
   output logic                  status_lamp_oe,
   output logic                  low_charge_alert_n,
   output logic                  low_charge_alert_oe,
   output logic                  fill_osc_en,
   output logic                  drain_osc_en,
   output logic                  leak_osc_en,
   output logic [CNT_W-1:0]      level
);

   logic [2:0] s_osc, s_drn, s_chg, s_scan, s_tck, s_sci, s_sel;
   logic [DIV_W-1:0]  div;
   logic [DIV_W-1:0]  next_div;
   logic [DIV_W-1:0]  blink_div;
   logic [DIV_W-1:0]  next_blink_div;
   logic [CNT_W-1:0]  cnt;
   logic [CNT_W-1:0]  next_cnt;
   logic [2:0]        tr_cnt;
   logic [2:0]        next_tr_cnt;
   logic              tr_leak;
   logic              next_tr_leak;
   logic              stopped_zero;
   logic              next_stopped_zero;
   logic [DIV_W:0]    al_div;
   logic [DIV_W:0]    next_al_div;
   logic [2:0]        al_left;
   logic [2:0]        next_al_left;
   logic              drn_q;
   logic              sel_q;
   logic              tick;
   logic              sect_tick;
   logic              scan_on;
   bctc_mode_type     mode;
   bctc_osc_sel_type  osc;
   bctc_switch_type   sw;
   logic              lamp_on;
   logic              lamp_oe;
   logic              alert_n;
   logic              alert_oe;

   // Two-flop synchronisers for every pin, third stage for edges
   always_ff @(posedge clk_sys)
   begin
      s_osc  <= {s_osc[1:0], osc_tick_in};
      s_drn  <= {s_drn[1:0], drain_detect_n};
      s_chg  <= {s_chg[1:0], charger_present};
      s_scan <= {s_scan[1:0], scan_select};
      s_tck  <= {s_tck[1:0], test_clock_in};
      s_sci  <= {s_sci[1:0], scan_serial_in};
      s_sel  <= {s_sel[1:0], scheme_pick};
   end

   assign scan_on = s_scan[1];
   assign drn_q   = s_drn[1];
   assign sel_q   = s_sel[1];
   // Test clock replaces the oscillator in scan mode
   assign tick = scan_on ? (s_tck[1] & ~s_tck[2]) : (s_osc[1] & ~s_osc[2]);

   function automatic int sections(input bctc_mode_type m);
      unique case (m)
         BCTC_CHARGE, BCTC_TRICKLE:     sections = SECT_CHARGE;
         BCTC_CHG_DIS, BCTC_DISCHARGE:  sections = SECT_DRAIN;
         BCTC_SELF_DIS:                 sections = SECT_LEAK;
      endcase
   endfunction

   // Mode from the charger and drain inputs
   always_comb
   begin
      if (!drn_q)
         mode = s_chg[1] ? BCTC_CHG_DIS : BCTC_DISCHARGE;
      else if (s_chg[1])
         mode = (cnt == CNT_MAX) ? BCTC_TRICKLE : BCTC_CHARGE;
      else
         mode = BCTC_SELF_DIS;
   end

   // Divider length chosen per mode: sections minus counter stages
   assign sect_tick = tick &
                      (div >= DIV_W'((64'd1 << (sections(mode) - CNT_W)) - 1));

   always_comb
   begin
      next_div          = div;
      next_cnt          = cnt;
      next_tr_cnt       = tr_cnt;
      next_tr_leak      = tr_leak;
      next_stopped_zero = stopped_zero;
      next_blink_div    = blink_div;
      if (scan_on && tick)
      begin
         // Chain: scan in -> divider -> counter -> scan out
         {next_div, next_cnt} = {s_sci[1], div, cnt[CNT_W-1:1]};
      end
      else if (tick)
      begin
         next_div = sect_tick ? '0 : div + DIV_W'(1);
         // Free-running so lamp taps do not depend on the mode's chain length
         next_blink_div = blink_div + DIV_W'(1);
         if (mode == BCTC_TRICKLE)
         begin
            // Alternate 4 fill periods then 3 leak periods
            if (tr_cnt == 3'((tr_leak ? TRICKLE_LEAK_N : TRICKLE_FILL_N) - 1))
            begin
               next_tr_cnt  = '0;
               next_tr_leak = ~tr_leak;
            end
            else
               next_tr_cnt = tr_cnt + 3'd1;
         end
         else
         begin
            next_tr_cnt  = '0;
            next_tr_leak = 1'b0;
         end
         if (sect_tick)
         begin
            unique case (mode)
               BCTC_CHARGE:    next_cnt = cnt + CNT_W'(1);
               BCTC_TRICKLE:   next_cnt = cnt;
               default:        next_cnt = (cnt == CNT_ZERO) ? cnt : cnt - CNT_W'(1);
            endcase
         end
      end
      if (mode == BCTC_DISCHARGE && cnt == CNT_ZERO)
         next_stopped_zero = 1'b1;
      else if (s_chg[1])
         next_stopped_zero = 1'b0;
   end

   // Alert: drain rising after stop at zero, four periods, charger aborts
   always_comb
   begin
      next_al_div  = al_div;
      next_al_left = al_left;
      if (s_chg[1])
      begin
         next_al_left = '0;
         next_al_div  = '0;
      end
      else if (drn_q && !s_drn[2] && stopped_zero)
      begin
         next_al_left = 3'(ALERT_PERIODS);
         next_al_div  = '0;
      end
      else if (al_left != '0 && tick)
      begin
         next_al_div = al_div + (DIV_W+1)'(1);
         if (al_div == (DIV_W+1)'((1 << (TAP_ALERT_1S + 1)) - 1))
         begin
            // Restart each period so all four periods are equal
            next_al_left = al_left - 3'd1;
            next_al_div  = '0;
         end
      end
   end

   // Output decode
   always_comb
   begin
      osc = '{fill_osc: 1'b0, drain_osc: 1'b0, leak_osc: 1'b0};
      sw  = '{switch_on: 1'b0, switch_off_n: 1'b1, switch_off_oe: 1'b1};
      lamp_on = 1'b0;
      lamp_oe = 1'b1;
      unique case (mode)
         BCTC_CHARGE:
         begin
            osc.fill_osc = 1'b1;
            sw.switch_on = 1'b1;
            lamp_on = sel_q ? blink_div[TAP_BLINK_Q_HZ] : 1'b1;
         end
         BCTC_TRICKLE:
         begin
            osc.fill_osc = ~tr_leak;
            osc.leak_osc = tr_leak;
            sw.switch_on = ~tr_leak;
            lamp_on = sel_q ? 1'b1 : blink_div[TAP_BLINK_1HZ];
         end
         BCTC_CHG_DIS:
         begin
            osc.drain_osc = 1'b1;
            sw.switch_on = 1'b1;
            lamp_on = sel_q ? blink_div[TAP_BLINK_5HZ] : 1'b1;
         end
         BCTC_DISCHARGE:
         begin
            osc.drain_osc = 1'b1;
            sw.switch_off_oe = 1'b0;
            lamp_oe = 1'b0;
         end
         BCTC_SELF_DIS:
         begin
            // Leak node keeps running while the alert needs its periods timed
            osc.leak_osc = (cnt != CNT_ZERO) | (al_left != '0);
            sw.switch_off_oe = 1'b0;
            lamp_oe = 1'b0;
         end
      endcase
      sw.switch_off_n = ~sw.switch_on;
      alert_oe = scan_on | (al_left != '0 & al_div[TAP_ALERT_1S]);
      alert_n  = scan_on ? cnt[0] : 1'b0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         div                 <= '0;
         blink_div           <= '0;
         cnt                 <= CNT_ZERO;
         tr_cnt              <= '0;
         tr_leak             <= 1'b0;
         stopped_zero        <= 1'b0;
         al_div              <= '0;
         al_left             <= '0;
         switch_on           <= 1'b0;
         switch_off_n        <= 1'b1;
         switch_off_oe       <= 1'b0;
         status_lamp_n       <= 1'b1;
         status_lamp_oe      <= 1'b0;
         low_charge_alert_n  <= 1'b1;
         low_charge_alert_oe <= 1'b0;
         fill_osc_en         <= 1'b0;
         drain_osc_en        <= 1'b0;
         leak_osc_en         <= 1'b0;
         level               <= '0;
      end
      else
      begin
         div                 <= next_div;
         blink_div           <= next_blink_div;
         cnt                 <= next_cnt;
         tr_cnt              <= next_tr_cnt;
         tr_leak             <= next_tr_leak;
         stopped_zero        <= next_stopped_zero;
         al_div              <= next_al_div;
         al_left             <= next_al_left;
         switch_on           <= sw.switch_on;
         switch_off_n        <= sw.switch_off_n;
         switch_off_oe       <= sw.switch_off_oe;
         status_lamp_n       <= ~lamp_on;
         status_lamp_oe      <= lamp_oe & lamp_on;
         low_charge_alert_n  <= alert_n;
         low_charge_alert_oe <= alert_oe;
         fill_osc_en         <= osc.fill_osc;
         drain_osc_en        <= osc.drain_osc;
         leak_osc_en         <= osc.leak_osc;
         level               <= cnt;
      end
   end

   a_count_up_charge: assert property (@(posedge clk_sys) disable iff (srst)
      (!scan_on && mode == BCTC_CHARGE && sect_tick) |=> cnt == $past(cnt) + CNT_W'(1))
      else $error("charge count did not rise");
   a_hold_max: assert property (@(posedge clk_sys) disable iff (srst)
      (!scan_on && mode == BCTC_TRICKLE) |=> cnt == CNT_MAX)
      else $error("trickle did not hold maximum");
   a_zero_stop: assert property (@(posedge clk_sys) disable iff (srst)
      (!scan_on && cnt == CNT_ZERO && !s_chg[1]) |=> cnt == CNT_ZERO)
      else $error("counter passed zero");
   a_switch_inverse: assert property (@(posedge clk_sys) disable iff (srst)
      switch_off_n == ~switch_on)
      else $error("complement switch not inverse");
   a_chgdis_switch: assert property (@(posedge clk_sys) disable iff (srst)
      (mode == BCTC_CHG_DIS) |=> (switch_on && drain_osc_en))
      else $error("charge/discharge switch wrong");
   a_discharge_off: assert property (@(posedge clk_sys) disable iff (srst)
      (mode == BCTC_DISCHARGE) |=> (!switch_on && !switch_off_oe && !status_lamp_oe))
      else $error("discharge outputs wrong");
   a_alert_abort: assert property (@(posedge clk_sys) disable iff (srst)
      (s_chg[1] && !scan_on) ##1 !scan_on |=> !low_charge_alert_oe)
      else $error("alert not aborted");
   a_alert_start: assert property (@(posedge clk_sys) disable iff (srst)
      (drn_q && !s_drn[2] && stopped_zero && !s_chg[1]) |=> al_left == 3'(ALERT_PERIODS))
      else $error("alert did not start");
   a_reset_charge: assert property (@(posedge clk_sys)
      srst |=> cnt == CNT_ZERO)
      else $error("reset did not clear counter");

endmodule

// *** shared/bctc_pkg.sv ***
// Purpose: Constants and types for the battery charge timer control block
// Assumes: One 250 MHz system clock; oscillator ticks arrive as inputs
// Notes:   Counts are in oscillator ticks after the mode-selected divider
package bctc_pkg;

   localparam int CLK_MHZ          = 250;
   localparam int CNT_W            = 10;
   localparam int DIV_W            = 17;
   localparam int SECT_CHARGE      = 22;
   localparam int SECT_DRAIN       = 18;
   localparam int SECT_LEAK        = 27;
   localparam int TRICKLE_FILL_N   = 4;
   localparam int TRICKLE_LEAK_N   = 3;
   localparam int ALERT_PERIODS    = 4;
   localparam int SCAN_LEN         = DIV_W + CNT_W;
   localparam int TAP_BLINK_1HZ    = 13;
   localparam int TAP_BLINK_Q_HZ   = 15;
   localparam int TAP_BLINK_5HZ    = 10;
   localparam int TAP_ALERT_1S     = 13;
   localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   typedef enum logic [2:0] {
      BCTC_CHARGE,
      BCTC_TRICKLE,
      BCTC_CHG_DIS,
      BCTC_DISCHARGE,
      BCTC_SELF_DIS
   } bctc_mode_type;

   typedef struct packed {
      logic fill_osc;
      logic drain_osc;
      logic leak_osc;
   } bctc_osc_sel_type;

   typedef struct packed {
      logic switch_on;
      logic switch_off_n;
      logic switch_off_oe;
   } bctc_switch_type;

endpackage

// *** verification/bctc_partner.sv ***
// Purpose: Oscillator and tester model on the far side of the charge timer
// Assumes: One clk_sys; the oscillator runs only while a timing node is enabled
// Notes:   Tick period is 2*TICK_HALF clocks; scan loop closed on request
`timescale 1ns/1ps
module bctc_partner
   import bctc_pkg::*;
#(
   parameter int TICK_HALF = 2
)
(
   input  wire logic clk_sys,
   input  wire logic fill_osc_en,
   input  wire logic drain_osc_en,
   input  wire logic leak_osc_en,
   input  wire logic low_charge_alert_n,
   input  wire logic loop_en,
   input  wire logic scan_bit,
   output logic      osc_tick_in,
   output logic      scan_serial_in
);
   int   half_cnt = 0;
   logic osc_q    = 1'b0;

   // Oscillator stands still while no timing node is enabled
   always_ff @(posedge clk_sys)
   begin
      if (fill_osc_en | drain_osc_en | leak_osc_en)
      begin
         if (half_cnt == TICK_HALF - 1)
         begin
            half_cnt <= 0;
            osc_q    <= ~osc_q;
         end
         else
            half_cnt <= half_cnt + 1;
      end
   end

   assign osc_tick_in = osc_q;
   // Output looped back to input for a readout that keeps the count
   assign scan_serial_in = loop_en ? low_charge_alert_n : scan_bit;
endmodule

// *** verification/bctc_tb_top.sv ***
// Purpose: Self-checking bench for the charge timer control core
// Assumes: Partner ticks every 4 clocks; pin changes settle within 8 clocks
// Notes:   Long blink and alert spans are sampled only in part
`timescale 1ns/1ps
module bctc_tb_top
   import bctc_pkg::*;
   ;
   localparam int TP    = 4;
   localparam int CHG_T = (1 << (SECT_CHARGE - CNT_W)) * TP;
   localparam int DRN_T = (1 << (SECT_DRAIN - CNT_W)) * TP;
   localparam int ALR_T = (1 << TAP_ALERT_1S) * TP;
   localparam int BLK_T = (1 << TAP_BLINK_5HZ) * TP;
   logic             clk_sys = 1'b0;
   logic             srst = 1'b1;
   logic             drain_detect_n = 1'b1;
   logic             charger_present = 1'b1;
   logic             scheme_pick = 1'b0;
   logic             scan_select = 1'b0;
   logic             test_clock_in = 1'b0;
   logic             loop_en = 1'b0;
   logic             scan_bit = 1'b0;
   logic             osc_tick_in, scan_serial_in, switch_on, switch_off_n, switch_off_oe;
   logic             status_lamp_n, status_lamp_oe, low_charge_alert_n, low_charge_alert_oe;
   logic             fill_osc_en, drain_osc_en, leak_osc_en;
   logic [CNT_W-1:0] level;
   int               error_cnt = 0;
   int               check_count = 0;
   logic [31:0]      rng = 32'h0000004c;

   always #2 clk_sys = ~clk_sys;

   bctc_core u_dut (.clk_sys(clk_sys), .srst(srst), .osc_tick_in(osc_tick_in),
      .drain_detect_n(drain_detect_n), .charger_present(charger_present),
      .scheme_pick(scheme_pick), .scan_select(scan_select), .test_clock_in(test_clock_in),
      .scan_serial_in(scan_serial_in), .switch_on(switch_on), .switch_off_n(switch_off_n),
      .switch_off_oe(switch_off_oe), .status_lamp_n(status_lamp_n),
      .status_lamp_oe(status_lamp_oe), .low_charge_alert_n(low_charge_alert_n),
      .low_charge_alert_oe(low_charge_alert_oe), .fill_osc_en(fill_osc_en),
      .drain_osc_en(drain_osc_en), .leak_osc_en(leak_osc_en), .level(level));

   bctc_partner #(.TICK_HALF(TP / 2)) u_partner (.clk_sys(clk_sys),
      .fill_osc_en(fill_osc_en), .drain_osc_en(drain_osc_en), .leak_osc_en(leak_osc_en),
      .low_charge_alert_n(low_charge_alert_n), .loop_en(loop_en), .scan_bit(scan_bit),
      .osc_tick_in(osc_tick_in), .scan_serial_in(scan_serial_in));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic chk_bit(input string nm, input logic exp, input logic got);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %b seen %b", nm, exp, got);
      end
   endtask

   task automatic chk_lvl(input string nm, input logic [CNT_W-1:0] exp,
                          input logic [CNT_W-1:0] got);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic pins(input logic chg, input logic dn);
      @(posedge clk_sys);
      charger_present <= chg;
      drain_detect_n  <= dn;
      cyc(8);
   endtask

   task automatic do_reset(input logic sel);
      @(posedge clk_sys);
      srst        <= 1'b1;
      scheme_pick <= sel;
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      cyc(8);
   endtask

   // Bounded wait for a counter value; t returns the cycles spent
   task automatic wait_lvl(input logic [CNT_W-1:0] exp, input int lim, output int t);
      t = 0;
      while (level !== exp && t < lim)
      begin
         cyc(1);
         t++;
      end
   endtask

   // One scan clock; o is the chain output seen before the rising edge
   task automatic shift(input logic b, output logic o);
      @(posedge clk_sys);
      scan_bit <= b;
      cyc(4);
      o = low_charge_alert_n;
      @(posedge clk_sys);
      test_clock_in <= 1'b1;
      cyc(4);
      @(posedge clk_sys);
      test_clock_in <= 1'b0;
      cyc(4);
   endtask

   task automatic end_of_test;
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      int               t;
      int               n;
      logic             o;
      logic [CNT_W-1:0] pat;
      logic [CNT_W-1:0] got;
      do_reset(1'b0);
      chk_lvl("level", CNT_ZERO, level);
      chk_bit("fill_osc_en", 1'b1, fill_osc_en);
      chk_bit("drain_osc_en", 1'b0, drain_osc_en);
      chk_bit("leak_osc_en", 1'b0, leak_osc_en);
      chk_bit("switch_off_n", 1'b0, switch_off_n);
      chk_bit("status_lamp_n", 1'b0, status_lamp_n);
      wait_lvl(10'h001, CHG_T + 100, t);
      chk_lvl("level", 10'h001, level);
      chk_bit("count span", 1'b1, t > CHG_T / 2);
      pins(1'b1, 1'b0);
      chk_bit("drain_osc_en", 1'b1, drain_osc_en);
      chk_bit("fill_osc_en", 1'b0, fill_osc_en);
      chk_bit("switch_on", 1'b1, switch_on);
      chk_bit("switch_off_n", 1'b0, switch_off_n);
      chk_bit("status_lamp_n", 1'b0, status_lamp_n);
      wait_lvl(CNT_ZERO, DRN_T + 100, t);
      chk_lvl("level", CNT_ZERO, level);
      chk_bit("status_lamp_n", 1'b0, status_lamp_n);
      pins(1'b0, 1'b0);
      chk_bit("switch_on", 1'b0, switch_on);
      chk_bit("switch_off_oe", 1'b0, switch_off_oe);
      chk_bit("status_lamp_oe", 1'b0, status_lamp_oe);
      cyc(DRN_T * 2);
      chk_lvl("level", CNT_ZERO, level);
      pins(1'b0, 1'b1);
      chk_bit("leak_osc_en", 1'b1, leak_osc_en);
      chk_bit("drain_osc_en", 1'b0, drain_osc_en);
      chk_bit("switch_on", 1'b0, switch_on);
      chk_bit("switch_off_n", 1'b1, switch_off_n);
      t = 0;
      while (!(low_charge_alert_oe === 1'b1 && low_charge_alert_n === 1'b0) && t < ALR_T + 100)
      begin
         cyc(1);
         t++;
      end
      chk_bit("alert active", 1'b1, low_charge_alert_oe === 1'b1);
      chk_lvl("level", CNT_ZERO, level);
      pins(1'b1, 1'b1);
      chk_bit("low_charge_alert_oe", 1'b0, low_charge_alert_oe);
      do_reset(1'b1);
      pins(1'b1, 1'b0);
      n = 0;
      o = status_lamp_n;
      repeat (BLK_T * 5 / 2)
      begin
         cyc(1);
         if (status_lamp_n !== o)
            n++;
         o = status_lamp_n;
      end
      chk_bit("alarm blink", 1'b1, n >= 2 && n <= 3);
      @(posedge clk_sys);
      scan_select <= 1'b1;
      cyc(8);
      chk_bit("low_charge_alert_oe", 1'b1, low_charge_alert_oe);
      rng = xs(rng);
      pat = rng[CNT_W-1:0];
      for (int i = 0; i < SCAN_LEN; i++)
      begin
         rng = xs(rng);
         shift((i < CNT_W) ? pat[i] : rng[0], o);
      end
      chk_lvl("scan load", pat, level);
      @(posedge clk_sys);
      loop_en <= 1'b1;
      for (int i = 0; i < SCAN_LEN; i++)
      begin
         shift(1'b0, o);
         if (i < CNT_W)
            got[i] = o;
      end
      chk_lvl("scan out", pat, got);
      chk_lvl("scan keep", pat, level);
      @(posedge clk_sys);
      scan_select <= 1'b0;
      loop_en     <= 1'b0;
      cyc(8);
      // Divider holds scanned bits; counting must resume within one drain period
      wait_lvl((pat == CNT_ZERO) ? CNT_ZERO : pat - CNT_W'(1), DRN_T + 100, t);
      chk_lvl("resume count", (pat == CNT_ZERO) ? CNT_ZERO : pat - CNT_W'(1), level);
      end_of_test();
   end

   initial
   begin
      repeat (100000) @(posedge clk_sys);
      error_cnt++;
      $display("ERROR watchdog expected done seen hang");
      end_of_test();
   end
endmodule
